// ===== include/ext_cfg_pkg.sv
// shared constants and types for the extended configuration target
package ext_cfg_pkg;

  // ==========================================================
  // bus command codes
  localparam logic [3:0] CMD_CFG_READ = 4'hA; // configuration read
  localparam logic [3:0] CMD_CFG_WRITE = 4'hB; // configuration write

  // ==========================================================
  // address field layout
  localparam int ADDR_W = 32; // address/data width
  localparam int CMD_W = 4; // command/byte-enable width
  localparam int EXT_MSB = 11; // top bit of extended register field
  localparam int EXT_LSB = 8; // low bit of extended register field
  localparam int TYPE_MSB = 1; // top bit of config type field
  localparam logic [1:0] CFG_TYPE0 = 2'h0; // type 0 config access
  localparam logic [3:0] EXT_NONE = 4'h0; // field value of basic space

  // ==========================================================
  // reset values
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000; // cleared word
  localparam logic [3:0] CMD_ZERO = 4'h0; // cleared command

  // ==========================================================
  // response speed encoding
  localparam logic SPEED_SLOW = 1'b1; // select one clock after strobe

  // ==========================================================
  // sequencer states, gray coded along the transfer path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, // waiting for an address phase
    ST_DECODE = 3'b001, // captured address being decoded
    ST_HIT = 3'b011, // select strobe raised
    ST_SELECT = 3'b010, // claimed, waiting for the data phase
    ST_DONE = 3'b110, // control lines driven inactive
    ST_RELEASE = 3'b111 // control lines floated
  } seq_state_t;

endpackage

// ===== hdl/ext_cfg_decode.sv
// address and command decoder for extended configuration accesses
`timescale 1ns/1ps
`default_nettype none

module ext_cfg_decode
  import ext_cfg_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr_i, // captured address
  input wire logic [CMD_W-1:0] cmd_i, // captured command
  output logic match_o, // access targets the extended region
  output logic write_o // access is a write
);

  // ==========================================================
  // decode
  logic is_cfg; // command is a configuration cycle
  logic is_ext; // register number lies above the basic space

  // configuration command of either direction
  assign is_cfg = (cmd_i == CMD_CFG_READ) || (cmd_i == CMD_CFG_WRITE);
  // type 0 access with a nonzero extended register field
  assign is_ext = (addr_i[TYPE_MSB:0] == CFG_TYPE0) &&
                  (addr_i[EXT_MSB:EXT_LSB] != EXT_NONE);
  assign match_o = is_cfg && is_ext;
  assign write_o = (cmd_i == CMD_CFG_WRITE);

endmodule
`default_nettype wire

// ===== hdl/ext_cfg_target.sv
// target sequencer for extended configuration reads and writes
// Behaviour
// - next clock: decode, present local address
// - region match raises select strobe in clock three
// - slow speed: devsel one clock after strobe
// - read: word strobe follows back-end ready by one cycle
// - two ready cycles: trdy with read word
// - read end: release lines, drop all signals
// - idle clock after: float devsel and trdy
// - write: trdy one cycle after back-end ready
// - write end: drop, then clear strobe, float
// - write: word strobe after irdy with ready
`timescale 1ns/1ps
`default_nettype none

module ext_cfg_target
  import ext_cfg_pkg::*;
(
  input wire logic CLK_I, // bus clock, 125 MHz
  input wire logic RST_N_I, // synchronous reset, active low
  input wire logic SELECT_RESPONSE_SPEED_I, // 1 slow, 0 medium
  input wire logic FRAME_N_I, // bus frame, active low
  input wire logic IDSEL_I, // configuration select
  input wire logic IRDY_N_I, // initiator ready, active low
  input wire logic [ADDR_W-1:0] AD_I, // address/data lines in
  input wire logic [CMD_W-1:0] CBE_N_I, // command/byte enables
  output logic [ADDR_W-1:0] AD_O, // address/data lines out
  output logic AD_OE_O, // drive enable of address/data lines
  output logic TRDY_N_O, // target ready, active low
  output logic TRDY_N_OE_O, // drive enable of target ready
  output logic DEVSEL_N_O, // device select, active low
  output logic DEVSEL_N_OE_O, // drive enable of device select
  input wire logic LOCAL_TARGET_READY_N_I, // back-end ready, low
  input wire logic [ADDR_W-1:0] LOCAL_DATA_I, // read word from back-end
  output logic [ADDR_W-1:0] LOCAL_ADDR_OUT_O, // decoded address
  output logic LOCAL_WRITE_O, // access direction, 1 write
  output logic EXT_CFG_HIT_O, // extended config select strobe
  output logic LOCAL_WORD_STROBE_N_O, // word transfer, active low
  output logic [ADDR_W-1:0] LOCAL_DATA_O // write word to back-end
);

  // ==========================================================
  // internal signals
  seq_state_t st; // sequencer state
  logic [CMD_W-1:0] cmd; // captured command
  logic match; // decoder: extended region hit
  logic is_write; // decoder: write command
  logic start; // address phase addressed to us
  logic xfer; // data phase completes this clock
  logic rdy_seen; // back-end ready in previous cycle

  // address phase with idsel, master keeps its side
  assign start = (st == ST_IDLE) && !FRAME_N_I && IDSEL_I;
  // irdy and trdy both low while claimed
  assign xfer = (st == ST_SELECT) && !IRDY_N_I && !TRDY_N_O;

  // ==========================================================
  // decoder
  ext_cfg_decode u_decode (
    .addr_i(LOCAL_ADDR_OUT_O),
    .cmd_i(cmd),
    .match_o(match),
    .write_o(is_write)
  );

  // ==========================================================
  // sequencer
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st <= ST_IDLE;
    end else begin
      case (st)
        ST_IDLE: if (start) st <= ST_DECODE;
        ST_DECODE: begin
          // no match: stay off the bus
          st <= match ? ST_HIT : ST_IDLE;
        end
        ST_HIT: st <= ST_SELECT;
        ST_SELECT: if (xfer) st <= ST_DONE;
        ST_DONE: st <= ST_RELEASE;
        ST_RELEASE: st <= ST_IDLE;
        default: st <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // address and command capture
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      LOCAL_ADDR_OUT_O <= WORD_ZERO;
      cmd <= CMD_ZERO;
    end else if (start) begin
      // shown to the back-end in the clock after the address
      LOCAL_ADDR_OUT_O <= AD_I;
      cmd <= CBE_N_I;
    end
  end

  // ==========================================================
  // select strobe and direction
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      EXT_CFG_HIT_O <= 1'b0;
      LOCAL_WRITE_O <= 1'b0;
    end else if (st == ST_DECODE && match) begin
      EXT_CFG_HIT_O <= 1'b1;
      LOCAL_WRITE_O <= is_write;
    end else if (xfer && !is_write) begin
      EXT_CFG_HIT_O <= 1'b0;
    end else if (st == ST_DONE) begin
      EXT_CFG_HIT_O <= 1'b0;
    end
  end

  // ==========================================================
  // device select, driven high while claimed but inactive
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      DEVSEL_N_O <= 1'b1;
      DEVSEL_N_OE_O <= 1'b0;
    end else begin
      // medium speed claims together with the strobe
      if (st == ST_DECODE && match && !SELECT_RESPONSE_SPEED_I) begin
        DEVSEL_N_O <= 1'b0;
        DEVSEL_N_OE_O <= 1'b1;
      end else if (st == ST_HIT) begin
        DEVSEL_N_O <= 1'b0;
        DEVSEL_N_OE_O <= 1'b1;
      end else if (xfer) begin
        DEVSEL_N_O <= 1'b1;
      end else if (st == ST_DONE) begin
        DEVSEL_N_OE_O <= 1'b0;
      end
    end
  end

  // ==========================================================
  // back-end ready history, counted only while claimed
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rdy_seen <= 1'b0;
    end else begin
      rdy_seen <= (st == ST_SELECT) && !LOCAL_TARGET_READY_N_I;
    end
  end

  // ==========================================================
  // target ready
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      TRDY_N_O <= 1'b1;
      TRDY_N_OE_O <= 1'b0;
    end else begin
      if (st == ST_HIT ||
          (st == ST_DECODE && match && !SELECT_RESPONSE_SPEED_I)) begin
        TRDY_N_OE_O <= 1'b1; // driven high with device select
      end else if (xfer) begin
        TRDY_N_O <= 1'b1;
      end else if (st == ST_DONE) begin
        TRDY_N_OE_O <= 1'b0;
      end else if (st == ST_SELECT && TRDY_N_O &&
                   !LOCAL_TARGET_READY_N_I) begin
        if (is_write) begin
          TRDY_N_O <= 1'b0;
        end else if (rdy_seen) begin
          TRDY_N_O <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // read word onto the bus
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      AD_O <= WORD_ZERO;
      AD_OE_O <= 1'b0;
    end else if (xfer) begin
      AD_OE_O <= 1'b0;
    end else if (st == ST_SELECT && !is_write && TRDY_N_O &&
                 !LOCAL_TARGET_READY_N_I && rdy_seen) begin
      AD_O <= LOCAL_DATA_I;
      AD_OE_O <= 1'b1;
    end
  end

  // ==========================================================
  // local word strobe
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      LOCAL_WORD_STROBE_N_O <= 1'b1;
    end else if (st == ST_SELECT) begin
      if (is_write) begin
        LOCAL_WORD_STROBE_N_O <= !xfer;
      end else begin
        // read: follows ready, dropped at completion
        LOCAL_WORD_STROBE_N_O <= LOCAL_TARGET_READY_N_I || xfer;
      end
    end else begin
      LOCAL_WORD_STROBE_N_O <= 1'b1;
    end
  end

  // ==========================================================
  // write word to the back-end
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      LOCAL_DATA_O <= WORD_ZERO;
    end else if (xfer && is_write) begin
      LOCAL_DATA_O <= AD_I;
    end
  end

  // ==========================================================
  // assertions
  property p_addr_out;
    @(posedge CLK_I) disable iff (!RST_N_I)
    start |=> LOCAL_ADDR_OUT_O == $past(AD_I);
  endproperty
  a_addr_out: assert property (p_addr_out)
    else $error("local address not shown after address phase");
  property p_hit;
    @(posedge CLK_I) disable iff (!RST_N_I)
    start ##1 match |=> EXT_CFG_HIT_O && st == ST_HIT;
  endproperty
  a_hit: assert property (p_hit)
    else $error("select strobe missing in third clock");
  property p_slow_sel;
    @(posedge CLK_I) disable iff (!RST_N_I)
    $rose(EXT_CFG_HIT_O) && SELECT_RESPONSE_SPEED_I
      |-> DEVSEL_N_O ##1 (!DEVSEL_N_O && DEVSEL_N_OE_O);
  endproperty
  a_slow_sel: assert property (p_slow_sel)
    else $error("slow device select not one clock after strobe");
  property p_rd_strobe;
    @(posedge CLK_I) disable iff (!RST_N_I)
    st == ST_SELECT && !is_write && !LOCAL_TARGET_READY_N_I && !xfer
      |=> !LOCAL_WORD_STROBE_N_O;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe)
    else $error("read word strobe did not follow ready");
  property p_rd_trdy;
    @(posedge CLK_I) disable iff (!RST_N_I)
    $fell(TRDY_N_O) && !LOCAL_WRITE_O
      |-> $past(rdy_seen) && !$past(LOCAL_TARGET_READY_N_I) &&
      AD_OE_O && AD_O == $past(LOCAL_DATA_I);
  endproperty
  a_rd_trdy: assert property (p_rd_trdy)
    else $error("read trdy without two ready cycles or wrong word");
  property p_rd_end;
    @(posedge CLK_I) disable iff (!RST_N_I)
    xfer && !is_write |=> DEVSEL_N_O && TRDY_N_O && !AD_OE_O &&
      !EXT_CFG_HIT_O && LOCAL_WORD_STROBE_N_O;
  endproperty
  a_rd_end: assert property (p_rd_end)
    else $error("read completion left a signal asserted");
  property p_float;
    @(posedge CLK_I) disable iff (!RST_N_I)
    xfer |=> DEVSEL_N_OE_O ##1 (!DEVSEL_N_OE_O && !TRDY_N_OE_O);
  endproperty
  a_float: assert property (p_float)
    else $error("devsel and trdy not floated in idle clock");
  property p_wr_trdy;
    @(posedge CLK_I) disable iff (!RST_N_I)
    st == ST_SELECT && is_write && !LOCAL_TARGET_READY_N_I && !xfer
      |=> !TRDY_N_O;
  endproperty
  a_wr_trdy: assert property (p_wr_trdy)
    else $error("write trdy not one cycle after ready");
  property p_wr_end;
    @(posedge CLK_I) disable iff (!RST_N_I)
    xfer && is_write |=> (DEVSEL_N_O && TRDY_N_O && EXT_CFG_HIT_O)
      ##1 (!EXT_CFG_HIT_O && LOCAL_WORD_STROBE_N_O && !DEVSEL_N_OE_O);
  endproperty
  a_wr_end: assert property (p_wr_end)
    else $error("write completion order broken");
  property p_wr_strobe;
    @(posedge CLK_I) disable iff (!RST_N_I)
    xfer && is_write |=> !LOCAL_WORD_STROBE_N_O &&
      LOCAL_DATA_O == $past(AD_I);
  endproperty
  a_wr_strobe: assert property (p_wr_strobe)
    else $error("write word strobe or word missing");
endmodule
`default_nettype wire

// ===== tb/ext_cfg_backend.sv
// back-end application model for the extended configuration target
`timescale 1ns/1ps
`default_nettype none

module ext_cfg_backend (
  input wire logic clk_i, // bus clock
  input wire logic hit_i, // select strobe from the target
  input wire logic devsel_n_i, // device select, active low
  input wire logic strobe_n_i, // word transfer strobe, active low
  input wire logic [3:0] wait_i, // claimed cycles before ready
  input wire logic [31:0] word_i, // read word to supply
  output logic ready_n_o, // back-end ready, active low
  output logic [31:0] data_o // read word to the target
);
  // ==========================================================
  // ready timing
  logic [3:0] count; // cycles spent in the claimed phase

  // start idle, not ready
  initial begin
    count = 4'h0;
    ready_n_o = 1'b1;
  end

  // ready once the wait runs out, dropped when claim ends
  always @(negedge clk_i) begin
    if (hit_i && !devsel_n_i) begin
      ready_n_o <= (count < wait_i) ? 1'b1 : 1'b0;
      count <= count + 4'h1;
    end else begin
      ready_n_o <= 1'b1;
      count <= 4'h0;
    end
  end

  // ==========================================================
  // read word only valid while strobed, inverted otherwise
  assign data_o = strobe_n_i ? ~word_i : word_i;

endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the extended configuration target
`timescale 1ns/1ps
`default_nettype none

module testbench
  import ext_cfg_pkg::*;
;
  // ==========================================================
  // stimulus and observed signals
  logic clk, rst_n, speed, frame_n, idsel, irdy_n; // bus master side
  logic [31:0] ad_drv, ad_bus, word, wdata; // data lines
  logic [3:0] cbe_n, wait_cyc; // command, back-end delay
  logic rdy_n, hit, stb_n, wr, ad_oe, trdy_n, trdy_oe, dev_n, dev_oe;
  logic [31:0] ad_o, l_addr, l_din, l_dout; // design data outputs
  logic [31:0] addr_seen, ad_seen, wd_seen; // captured values
  logic oe_seen, wr_seen; // captured flags
  int t_hit, t_dev, t_trdy, t_stb, t_rel, t_clr, t_flt, cycles;
  int miscompares, checks_done; // error and check counts

  // bus lines resolved from both parties
  assign ad_bus = ad_oe ? ad_o : ad_drv;

  ext_cfg_target i_dut (.CLK_I(clk), .RST_N_I(rst_n),
    .SELECT_RESPONSE_SPEED_I(speed), .FRAME_N_I(frame_n),
    .IDSEL_I(idsel), .IRDY_N_I(irdy_n), .AD_I(ad_bus), .CBE_N_I(cbe_n),
    .AD_O(ad_o), .AD_OE_O(ad_oe), .TRDY_N_O(trdy_n),
    .TRDY_N_OE_O(trdy_oe), .DEVSEL_N_O(dev_n), .DEVSEL_N_OE_O(dev_oe),
    .LOCAL_TARGET_READY_N_I(rdy_n), .LOCAL_DATA_I(l_din),
    .LOCAL_ADDR_OUT_O(l_addr), .LOCAL_WRITE_O(wr),
    .EXT_CFG_HIT_O(hit), .LOCAL_WORD_STROBE_N_O(stb_n),
    .LOCAL_DATA_O(l_dout));

  ext_cfg_backend i_backend (.clk_i(clk), .hit_i(hit),
    .devsel_n_i(dev_n | ~dev_oe), .strobe_n_i(stb_n), .wait_i(wait_cyc),
    .word_i(word), .ready_n_o(rdy_n), .data_o(l_din));

  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end

  // ==========================================================
  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // one access as bus master, logging cycle of each event
  task automatic run(input logic w, input logic [31:0] addr);
    {t_hit, t_dev, t_trdy, t_stb, t_rel, t_clr, t_flt} = '0;
    @(negedge clk);
    frame_n = 1'b0;
    irdy_n = 1'b1;
    idsel = 1'b1;
    ad_drv = addr;
    cbe_n = w ? CMD_CFG_WRITE : CMD_CFG_READ;
    for (int c = 2; c <= 16; c++) begin
      @(negedge clk);
      if (c == 2) addr_seen = l_addr;
      if (hit && t_hit == 0) begin
        t_hit = c;
        wr_seen = wr;
      end
      if (!dev_n && dev_oe && t_dev == 0) t_dev = c;
      if (t_trdy != 0 && t_rel == 0 && dev_n) t_rel = c;
      if (t_dev != 0 && !dev_oe && !trdy_oe && t_flt == 0) t_flt = c;
      if (t_hit != 0 && !hit && t_clr == 0) t_clr = c;
      if (!stb_n && t_stb == 0) begin
        t_stb = c;
        wd_seen = l_dout;
      end
      if (!trdy_n && trdy_oe && t_trdy == 0) begin
        t_trdy = c;
        ad_seen = ad_o;
        oe_seen = ad_oe;
      end
      frame_n = 1'b1;
      idsel = 1'b0;
      cbe_n = (t_trdy != 0 && c > t_trdy) ? 4'hF : 4'h0;
      irdy_n = (t_trdy != 0 && c > t_trdy);
      ad_drv = (w && irdy_n == 1'b0) ? wdata : ~ad_drv;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic read_slow(input logic [3:0] w);
    speed = SPEED_SLOW;
    wait_cyc = w;
    word = 32'hA5C3_0F1E + 32'(w);
    run(1'b0, 32'h0000_0A40);
    check(addr_seen, 32'h0000_0A40);
    check(32'(t_hit), 32'h3);
    check({31'h0, wr_seen}, 32'h0);
    check(32'(t_dev), 32'h4);
    check(32'(t_stb), 32'(5 + w));
    check(32'(t_trdy), 32'(6 + w));
    check(ad_seen, word);
    check({31'h0, oe_seen}, 32'h1);
    check(32'(t_rel), 32'(7 + w));
    check(32'(t_clr), 32'(7 + w));
    check(32'(t_flt), 32'(8 + w));
  endtask

  task automatic write_slow(input logic [3:0] w);
    speed = SPEED_SLOW;
    wait_cyc = w;
    wdata = 32'h3C96_E187 ^ 32'(w);
    run(1'b1, 32'h0000_F104);
    check(32'(t_hit), 32'h3);
    check({31'h0, wr_seen}, 32'h1);
    check(32'(t_dev), 32'h4);
    check(32'(t_trdy), 32'(5 + w));
    check(32'(t_rel), 32'(6 + w));
    check(32'(t_stb), 32'(6 + w));
    check(wd_seen, wdata);
    check(32'(t_clr), 32'(7 + w));
    check(32'(t_flt), 32'(7 + w));
  endtask

  task automatic no_match();
    speed = SPEED_SLOW;
    wait_cyc = 4'h0;
    run(1'b0, 32'h0000_00F0);
    check(32'(t_hit + t_dev), 32'h0);
    run(1'b0, 32'h0000_0301);
    check(32'(t_hit + t_dev), 32'h0);
  endtask

  // medium speed: devsel comes together with the strobe
  task automatic medium_speed();
    speed = ~SPEED_SLOW;
    wait_cyc = 4'h0;
    word = 32'h5A3C_F0E1;
    run(1'b0, 32'h0000_0200);
    check(32'(t_hit), 32'h3);
    check(32'(t_dev), 32'h3);
    check(ad_seen, word);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {miscompares, checks_done, cycles} = '0;
    {rst_n, frame_n, idsel, irdy_n, speed} = 5'h0A;
    {ad_drv, word, wdata, cbe_n, wait_cyc} = '0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    read_slow(4'h0);
    read_slow(4'h2);
    write_slow(4'h0);
    write_slow(4'h2);
    no_match();
    medium_speed();
    results();
  end

endmodule
`default_nettype wire
